// file: ripple_pkg.sv
// Shared constants and types of the ripple-count positioner
package ripple_pkg;
    localparam int CLK_HZ      = 100_000_000;
    localparam int DEBOUNCE_US = 1000;
    localparam int STALL_MS    = 200;
    localparam int STOP_MS     = 100;
    localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);
    localparam int STALL_TO_CYC = STALL_MS * (CLK_HZ / 1000);
    localparam int STOP_TO_CYC  = STOP_MS * (CLK_HZ / 1000);

    localparam int NUM_CH = 3;
    localparam int NUM_BR = 6;
    localparam int CNT_W  = 16;
    localparam int TMR_W  = 25;
    localparam int DEB_W  = 17;

    // APB byte offsets
    localparam logic [7:0] CMD_OFS   = 8'h00;
    localparam logic [7:0] STAT1_OFS = 8'h04;
    localparam logic [7:0] STAT2_OFS = 8'h08;
    localparam logic [7:0] STAT3_OFS = 8'h0C;

    // Command word fields
    localparam int CMD_MOT_LSB  = 0;
    localparam int CMD_DIR_BIT  = 3;
    localparam int CMD_GAIN_LSB = 4;
    localparam int CMD_CNT_LSB  = 8;
    localparam int CMD_W        = 24;
    localparam int CMD_LINE_BIT = 30;
    localparam int CMD_REF_BIT  = 31;

    // Status word fields
    localparam int STAT_BUSY_BIT  = 16;
    localparam int STAT_STALL_BIT = 17;
    localparam int STAT_VOLT_BIT  = 18;
    localparam int STAT_INVAL_BIT = 19;
    localparam int STAT_DONE_BIT  = 20;
    localparam int STAT_BRAKE_BIT = 21;

    // Motor number minus one -> channel and lower bridge index
    localparam logic [1:0] MOT_CHAN [5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h2};
    localparam logic [2:0] MOT_BR   [5] = '{3'h0, 3'h2, 3'h4, 3'h1, 3'h3};

    typedef enum logic [1:0] {
        GAIN_LOW  = 2'h0,
        GAIN_MED  = 2'h1,
        GAIN_HIGH = 2'h2
    } gain_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h1,
        ST_RUN   = 3'h2,
        ST_BRAKE = 3'h4
    } ch_state_t;
endpackage

// file: ch_if.sv
// Command and status bundle between the top and one ripple channel
`timescale 1ns/1ns
interface ch_if;
    import ripple_pkg::*;
    logic             start;
    logic [2:0]       bridge;
    logic             dir;
    gain_t            gain;
    logic [CNT_W-1:0] target;
    logic             ripple;
    logic             volt_fault;
    logic             hard_fault;
    logic             ack;
    ch_state_t        state;
    logic [CNT_W-1:0] count;
    logic             stall;
    logic             vflag;
    logic             invalid;
    logic             done;
    logic [2:0]       bridge_q;
    logic             dir_q;
    gain_t            gain_q;

    modport ctrl (output start, bridge, dir, gain, target, ripple, volt_fault, hard_fault, ack,
                  input state, count, stall, vflag, invalid, done, bridge_q, dir_q, gain_q);
    modport chan (input start, bridge, dir, gain, target, ripple, volt_fault, hard_fault, ack,
                  output state, count, stall, vflag, invalid, done, bridge_q, dir_q, gain_q);
endinterface

// file: ripple_channel.sv
// One ripple channel: move sequencer, counter, stall and stop timers
`timescale 1ns/1ns
module ripple_channel
    import ripple_pkg::*;
#(
    parameter int STALL_CYC = STALL_TO_CYC,
    parameter int STOP_CYC  = STOP_TO_CYC
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Control bundle
    ch_if.chan        c
);
    ch_state_t        state_q, state_d;
    logic [CNT_W-1:0] count_q, count_d, target_q, target_d;
    logic [TMR_W-1:0] tmr_q, tmr_d;
    logic             stall_q, stall_d, vflag_q, vflag_d, inval_q, inval_d;
    logic             done_q, done_d, done_set;
    logic [2:0]       bridge_q, bridge_d;
    logic             dir_q, dir_d;
    gain_t            gain_q, gain_d;

    always_comb begin
        state_d  = state_q;
        count_d  = count_q;
        target_d = target_q;
        tmr_d    = TMR_W'(tmr_q + TMR_W'(1));
        stall_d  = stall_q;
        vflag_d  = vflag_q;
        inval_d  = inval_q;
        bridge_d = bridge_q;
        dir_d    = dir_q;
        gain_d   = gain_q;
        done_set = 1'b0;
        case (state_q)
            ST_IDLE: begin
                tmr_d = '0;
                if (c.start) begin
                    state_d  = (c.target == '0) ? ST_BRAKE : ST_RUN; // [RL9]
                    count_d  = '0;
                    target_d = c.target;
                    bridge_d = c.bridge;
                    dir_d    = c.dir;
                    gain_d   = c.gain; // [RL3]
                    stall_d  = 1'b0;
                    vflag_d  = 1'b0;
                    inval_d  = 1'b0;
                end
            end
            ST_RUN: begin
                if (c.hard_fault) begin
                    state_d  = ST_IDLE; // [RL15]
                    inval_d  = 1'b1;
                    done_set = 1'b1;
                end else if (c.ripple) begin
                    count_d = CNT_W'(count_q + CNT_W'(1)); // [RL9]
                    tmr_d   = '0; // [RL18]
                    // Only here may a target hit turn drive into brake
                    if (count_d >= target_q) begin
                        state_d = ST_BRAKE; // [RL4]
                    end
                end else if (c.volt_fault) begin
                    state_d = ST_BRAKE; // [RL13]
                    vflag_d = 1'b1;
                    tmr_d   = '0;
                end else if (tmr_q == TMR_W'(STALL_CYC - 1)) begin
                    state_d = ST_BRAKE; // [RL6]
                    stall_d = 1'b1; // [RL7]
                    tmr_d   = '0;
                end
            end
            ST_BRAKE: begin
                if (c.hard_fault) begin
                    state_d  = ST_IDLE; // [RL15]
                    inval_d  = 1'b1;
                    done_set = 1'b1;
                end else if (c.ripple) begin
                    count_d = CNT_W'(count_q + CNT_W'(1)); // [RL13]
                    tmr_d   = '0; // [RL18]
                end else if (tmr_q == TMR_W'(STOP_CYC - 1)) begin
                    state_d  = ST_IDLE; // [RL10] [RL17]
                    done_set = 1'b1; // [RL11] [RL14]
                end
            end
            default: state_d = ST_IDLE;
        endcase
        // Set wins over a read clear in the same cycle
        done_d = done_set | (done_q & ~c.ack);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= ST_IDLE;
            count_q  <= '0;
            target_q <= '0;
            tmr_q    <= '0;
            stall_q  <= 1'b0;
            vflag_q  <= 1'b0;
            inval_q  <= 1'b0;
            done_q   <= 1'b0;
            bridge_q <= 3'h0;
            dir_q    <= 1'b0;
            gain_q   <= GAIN_LOW;
        end else begin
            state_q  <= state_d;
            count_q  <= count_d;
            target_q <= target_d;
            tmr_q    <= tmr_d;
            stall_q  <= stall_d;
            vflag_q  <= vflag_d;
            inval_q  <= inval_d;
            done_q   <= done_d;
            bridge_q <= bridge_d;
            dir_q    <= dir_d;
            gain_q   <= gain_d;
        end
    end

    assign c.state    = state_q;
    assign c.count    = count_q;
    assign c.stall    = stall_q;
    assign c.vflag    = vflag_q;
    assign c.invalid  = inval_q;
    assign c.done     = done_q;
    assign c.bridge_q = bridge_q;
    assign c.dir_q    = dir_q;
    assign c.gain_q   = gain_q;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_brake_entry;
        (state_q == ST_RUN) ##1 (state_q == ST_BRAKE && !stall_q && !vflag_q)
            |-> $past(c.ripple) && $past(count_d) >= target_q;
    endproperty
    a_brake_entry: assert property (p_brake_entry) else $error("brake entered between ripples"); // [RL4]

    property p_stall;
        state_q == ST_RUN && tmr_q == TMR_W'(STALL_CYC - 1) && !c.ripple && !c.hard_fault
            && !c.volt_fault |=> state_q == ST_BRAKE && stall_q;
    endproperty
    a_stall: assert property (p_stall) else $error("stall timeout not taken"); // [RL6] [RL7]

    property p_stop;
        state_q == ST_BRAKE && tmr_q == TMR_W'(STOP_CYC - 1) && !c.ripple && !c.hard_fault
            |=> state_q == ST_IDLE && done_q;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not declared"); // [RL10]

    property p_hard;
        state_q != ST_IDLE && c.hard_fault |=> state_q == ST_IDLE && inval_q && done_q;
    endproperty
    a_hard: assert property (p_hard) else $error("hard fault not handled"); // [RL15]

    property p_volt;
        state_q == ST_RUN && c.volt_fault && !c.hard_fault && !c.ripple
            |=> state_q == ST_BRAKE && vflag_q;
    endproperty
    a_volt: assert property (p_volt) else $error("voltage fault did not brake"); // [RL13]

    property p_restart;
        state_q != ST_IDLE && c.ripple && !c.hard_fault |=> tmr_q == '0 ##1
            (tmr_q <= TMR_W'(1) || state_q == ST_IDLE);
    endproperty
    a_restart: assert property (p_restart) else $error("timer not restarted"); // [RL18]

    c_stall: cover property (state_q == ST_RUN ##1 state_q == ST_BRAKE && stall_q);
    c_stop:  cover property (state_q == ST_BRAKE ##1 state_q == ST_IDLE && !inval_q);
    c_hard:  cover property (state_q == ST_RUN ##1 state_q == ST_IDLE && inval_q);
endmodule

// file: ripple_count_positioner.sv
// Top of the ripple-count positioner: APB registers, debounce, bridge drive
`timescale 1ns/1ns
// Overview of operation
// RL1: Pulse and sine paths merge; one debounce window stops double counting.
// RL2: Sense input moves to the opposite low side while braking.
// RL3: Each channel keeps its own gain, low, medium or high, set by host.
// RL4: Drive turns to brake on target only in a ripple-accept cycle.
// RL5: After an accepted rising edge, further edges are ignored for 1 ms.
// RL6: No ripple for 200 ms while driving declares stall and brakes.
// RL7: Stall latches a diagnostic readable with the count.
// RL8: Host sends motor, direction, count and gain to start a move.
// RL9: Move drives the addressed pair, counts to target, then brakes counting.
// RL10: In brake, 100 ms without ripple declares the motor stopped.
// RL11: On stop, data-ready goes low and the full count is readable.
// RL12: Host tracks position from read count; no reverse correction.
// RL13: Over/undervoltage or stall brakes with both low sides, still counting.
// RL14: After voltage fault or stall, data-ready and count with diagnostics.
// RL15: Overcurrent or overtemperature tristates, stops counting, flags invalid.
// RL16: Motors map to channels and bridge pairs; motors 4, 5 share channels.
// RL17: After stop in brake, the pair returns to high impedance.
// RL18: Stall and stop timers restart per ripple; channels independent.
module ripple_count_positioner
    import ripple_pkg::*;
#(
    parameter int DEB_CYC   = DEBOUNCE_CYC,
    parameter int STALL_CYC = STALL_TO_CYC,
    parameter int STOP_CYC  = STOP_TO_CYC
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic [7:0]        paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Digitised ripple detector outputs per channel
    input  wire logic [NUM_CH-1:0] pulse_det,
    input  wire logic [NUM_CH-1:0] sine_det,
    // Supervisor inputs
    input  wire logic              bat_overvolt,
    input  wire logic              bat_undervolt,
    input  wire logic [NUM_BR-1:0] overcurrent,
    input  wire logic              overtemp,
    // Half bridge drive; both off means high impedance
    output logic      [NUM_BR-1:0] hs_on,
    output logic      [NUM_BR-1:0] ls_on,
    // Analog front end control
    output logic      [2*NUM_CH-1:0] gain_sel,
    output logic      [NUM_CH-1:0] sense_other,
    output logic      [NUM_CH-1:0] mux_alt,
    // Open-drain data-ready pin
    input  wire logic              data_ready_flag_n_in,
    output logic                   data_ready_flag_n_out,
    output logic                   data_ready_flag_n_oe
);
    ch_if chs [NUM_CH] ();

    ch_state_t        st   [NUM_CH];
    logic [2:0]       br   [NUM_CH];
    logic             dr   [NUM_CH];
    logic [CNT_W-1:0] cnt  [NUM_CH];
    logic [31:0]      stat [NUM_CH];
    logic [NUM_CH-1:0] acc, done_v, busy_v;

    // Bus side registers
    logic [CMD_W-1:0]  cmd_q, cmd_d;
    logic [2:0]        cbr_q, cbr_d;
    logic              ref_q, ref_d;
    logic [NUM_CH-1:0] start_q, start_d;
    logic [31:0]       prdata_q, prdata_d;
    logic [NUM_CH-1:0] stat_sel, ack;
    logic              hit;
    logic [31:0]       rd_word;
    logic [2:0]        mot, idx, cbr;
    logic [1:0]        cch;
    logic              mot_ok, conflict;
    logic [NUM_BR-1:0] used;

    // Output registers
    logic [NUM_BR-1:0] hs_q, hs_d, ls_q, ls_d;
    logic [NUM_CH-1:0] sense_q, sense_d, mux_q, mux_d;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic             raw_q, raw_d;
        logic [DEB_W-1:0] deb_q, deb_d;

        // Both paths feed one edge, so one commutation counts once
        always_comb begin
            raw_d  = pulse_det[i] | sine_det[i]; // [RL1]
            acc[i] = raw_d & ~raw_q & (deb_q == '0) & (st[i] != ST_IDLE); // [RL5]
            if (acc[i]) begin
                deb_d = DEB_W'(DEB_CYC);
            end else if (deb_q != '0) begin
                deb_d = DEB_W'(deb_q - DEB_W'(1));
            end else begin
                deb_d = deb_q;
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                raw_q <= 1'b0;
                deb_q <= '0;
            end else begin
                raw_q <= raw_d;
                deb_q <= deb_d;
            end
        end

        ripple_channel #(
            .STALL_CYC (STALL_CYC),
            .STOP_CYC  (STOP_CYC)
        ) u_chan (
            .pclk    (pclk),
            .presetn (presetn),
            .c       (chs[i])
        );

        assign chs[i].start      = start_q[i];
        assign chs[i].bridge     = cbr_q;
        assign chs[i].dir        = cmd_q[CMD_DIR_BIT];
        assign chs[i].gain       = gain_t'(cmd_q[CMD_GAIN_LSB +: 2]); // [RL3]
        assign chs[i].target     = cmd_q[CMD_CNT_LSB +: CNT_W];
        assign chs[i].ripple     = acc[i];
        assign chs[i].volt_fault = bat_overvolt | bat_undervolt; // [RL13]
        assign chs[i].hard_fault = overtemp | overcurrent[br[i]]
                                 | overcurrent[3'(br[i] + 3'h1)]; // [RL15]
        assign chs[i].ack        = ack[i];
        assign st[i]     = chs[i].state;
        assign br[i]     = chs[i].bridge_q;
        assign dr[i]     = chs[i].dir_q;
        assign cnt[i]    = chs[i].count;
        assign done_v[i] = chs[i].done;
        assign busy_v[i] = (st[i] != ST_IDLE) | start_q[i];
        assign gain_sel[2*i +: 2] = chs[i].gain_q;

        always_comb begin
            stat[i] = 32'h0;
            stat[i][CNT_W-1:0]      = cnt[i]; // [RL11]
            stat[i][STAT_BUSY_BIT]  = busy_v[i];
            stat[i][STAT_STALL_BIT] = chs[i].stall; // [RL7]
            stat[i][STAT_VOLT_BIT]  = chs[i].vflag; // [RL14]
            stat[i][STAT_INVAL_BIT] = chs[i].invalid; // [RL15]
            stat[i][STAT_DONE_BIT]  = done_v[i];
            stat[i][STAT_BRAKE_BIT] = st[i] == ST_BRAKE;
        end

        property p_deb_gap;
            acc[i] |=> deb_q == DEB_W'(DEB_CYC) && !acc[i];
        endproperty
        a_deb_gap: assert property (@(posedge pclk) disable iff (!presetn) p_deb_gap)
            else $error("edge accepted inside debounce"); // [RL5]

        property p_one_count;
            acc[i] && st[i] != ST_IDLE && !chs[i].hard_fault
                |=> cnt[i] == CNT_W'($past(cnt[i]) + CNT_W'(1));
        endproperty
        a_one_count: assert property (@(posedge pclk) disable iff (!presetn) p_one_count)
            else $error("ripple not counted exactly once"); // [RL1]

        property p_brake_bridges;
            st[i] == ST_BRAKE |=> ls_on[$past(br[i])] && ls_on[3'($past(br[i]) + 3'h1)]
                && !hs_on[$past(br[i])] && !hs_on[3'($past(br[i]) + 3'h1)];
        endproperty
        a_brake_bridges: assert property (@(posedge pclk) disable iff (!presetn)
            p_brake_bridges) else $error("brake pair not on low sides"); // [RL9]

        property p_sense;
            st[i] == ST_BRAKE ##1 st[i] == ST_BRAKE |-> sense_other[i];
        endproperty
        a_sense: assert property (@(posedge pclk) disable iff (!presetn) p_sense)
            else $error("sense not moved in brake"); // [RL2]

        property p_drdy;
            st[i] != ST_IDLE ##1 st[i] == ST_IDLE |-> data_ready_flag_n_oe
                && !data_ready_flag_n_out;
        endproperty
        a_drdy: assert property (@(posedge pclk) disable iff (!presetn) p_drdy)
            else $error("data ready not raised at stop"); // [RL11]
    end

    // Register map and command decode
    always_comb begin
        hit      = 1'b1;
        rd_word  = 32'h0;
        stat_sel = '0;
        if (paddr == CMD_OFS) begin
            rd_word = {ref_q, ~data_ready_flag_n_in, 6'h0, cmd_q};
        end else if (paddr == STAT1_OFS) begin
            stat_sel = 3'h1;
            rd_word  = stat[0];
        end else if (paddr == STAT2_OFS) begin
            stat_sel = 3'h2;
            rd_word  = stat[1];
        end else if (paddr == STAT3_OFS) begin
            stat_sel = 3'h4;
            rd_word  = stat[2];
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        mot    = pwdata[CMD_MOT_LSB +: 3]; // [RL8]
        mot_ok = (mot >= 3'h1) && (mot <= 3'h5);
        idx    = mot_ok ? 3'(mot - 3'h1) : 3'h0;
        cch    = MOT_CHAN[idx]; // [RL16]
        cbr    = MOT_BR[idx];
        used   = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (busy_v[i]) begin
                used[br[i]] = 1'b1;
                used[3'(br[i] + 3'h1)] = 1'b1;
            end
        end
        // A shared channel or bridge cannot take a second motor
        conflict = used[cbr] | used[3'(cbr + 3'h1)]; // [RL16]
        cmd_d    = cmd_q;
        cbr_d    = cbr_q;
        ref_d    = ref_q;
        start_d  = '0;
        if (psel && penable && pwrite && paddr == CMD_OFS) begin
            cmd_d = pwdata[CMD_W-1:0];
            ref_d = ~mot_ok | conflict;
            if (mot_ok && !conflict) begin
                cbr_d        = cbr;
                start_d[cch] = 1'b1; // [RL9]
            end
        end
        prdata_d = (psel && !penable) ? rd_word : prdata_q;
        ack      = (psel && penable && !pwrite) ? stat_sel : '0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q    <= '0;
            cbr_q    <= 3'h0;
            ref_q    <= 1'b0;
            start_q  <= '0;
            prdata_q <= 32'h0;
        end else begin
            cmd_q    <= cmd_d;
            cbr_q    <= cbr_d;
            ref_q    <= ref_d;
            start_q  <= start_d;
            prdata_q <= prdata_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // Bridge drive; an idle pair is left in high impedance
    always_comb begin
        hs_d    = '0;
        ls_d    = '0;
        sense_d = '0;
        mux_d   = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            mux_d[i] = (i == 0 && br[i] == MOT_BR[3]) || (i == 2 && br[i] == MOT_BR[4]); // [RL16]
            if (st[i] == ST_RUN) begin
                if (dr[i]) begin
                    hs_d[br[i]] = 1'b1;
                    ls_d[3'(br[i] + 3'h1)] = 1'b1;
                end else begin
                    ls_d[br[i]] = 1'b1;
                    hs_d[3'(br[i] + 3'h1)] = 1'b1;
                end
            end else if (st[i] == ST_BRAKE) begin
                ls_d[br[i]] = 1'b1; // [RL13]
                ls_d[3'(br[i] + 3'h1)] = 1'b1;
                // Generator current reverses, so measure the other switch
                sense_d[i] = 1'b1; // [RL2]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_q    <= '0;
            ls_q    <= '0;
            sense_q <= '0;
            mux_q   <= '0;
        end else begin
            hs_q    <= hs_d;
            ls_q    <= ls_d;
            sense_q <= sense_d;
            mux_q   <= mux_d;
        end
    end

    assign hs_on       = hs_q;
    assign ls_on       = ls_q;
    assign sense_other = sense_q;
    assign mux_alt     = mux_q;
    assign data_ready_flag_n_out = 1'b0;
    assign data_ready_flag_n_oe  = |done_v; // [RL11] [RL14]

    property p_idle_tristate;
        st[0] == ST_IDLE && st[1] == ST_IDLE && st[2] == ST_IDLE
            |=> hs_on == '0 && ls_on == '0;
    endproperty
    a_idle_tristate: assert property (@(posedge pclk) disable iff (!presetn)
        p_idle_tristate) else $error("idle bridges not tristated"); // [RL17]

    c_two_moves: cover property (@(posedge pclk) disable iff (!presetn)
        st[0] == ST_RUN && st[1] == ST_RUN);
endmodule

// file: motor_model.sv
// Motor model: ripples while pair one drives, two run-out ripples in brake
`timescale 1ns/1ns
module motor_model (
    // Clock and stall control
    input  wire logic       pclk,
    input  wire logic       stalled,
    // Bridge drive
    input  wire logic [5:0] hs_on,
    input  wire logic [5:0] ls_on,
    // Ripple paths; echo lands inside the debounce window
    output logic            ripple,
    output logic            echo
);
    int         ph = 0;
    int         runout = 0;
    logic [3:0] dly = 4'h0;
    initial ripple = 1'b0;
    initial echo = 1'b0;
    always @(posedge pclk) begin
        ph <= (ph == 39) ? 0 : ph + 1;
        dly <= {dly[2:0], ripple};
        echo <= dly[3];
        ripple <= 1'b0;
        if (ph == 39 && !stalled && (|hs_on[1:0] || (&ls_on[1:0] && runout < 2))) begin
            ripple <= 1'b1;
            runout <= (&ls_on[1:0]) ? runout + 1 : 0;
        end
    end
endmodule

// file: ripple_count_positioner_bench.sv
// Self-checking bench of the ripple-count positioner
`timescale 1ns/1ns
module ripple_count_positioner_bench;
    import ripple_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        stalled = 1'b0;
    logic        bat_hi = 1'b0;
    logic        bat_lo = 1'b0;
    logic        hot = 1'b0;
    logic [5:0]  oc_bits = 6'h00;
    logic [2:0]  sense_v;
    logic [2:0]  mux_v;
    logic        ripple;
    logic        echo;
    logic [5:0]  hs_on;
    logic [5:0]  ls_on;
    logic [5:0]  gain_sel;
    logic        dr_out;
    logic        dr_oe;
    wire         dr_line = dr_oe ? dr_out : 1'b1;
    logic [31:0] rd;
    logic        err;
    int          error_cnt = 0;
    int          checks_done = 0;

    ripple_count_positioner #(.DEB_CYC(20), .STALL_CYC(200), .STOP_CYC(100)) DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pulse_det({2'h0, ripple}), .sine_det({2'h0, echo}),
        .bat_overvolt(bat_hi), .bat_undervolt(bat_lo), .overcurrent(oc_bits), .overtemp(hot),
        .hs_on(hs_on), .ls_on(ls_on), .gain_sel(gain_sel),
        .sense_other(sense_v), .mux_alt(mux_v),
        .data_ready_flag_n_in(dr_line), .data_ready_flag_n_out(dr_out),
        .data_ready_flag_n_oe(dr_oe));

    motor_model motor (.pclk(pclk), .stalled(stalled), .hs_on(hs_on), .ls_on(ls_on),
        .ripple(ripple), .echo(echo));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_dr;
        int n;
        n = 0;
        while (dr_line !== 1'b0 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
    endtask

    task automatic t_bad;
        apb(1'b0, STAT1_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, CMD_OFS, 32'h0);
        apb(1'b0, CMD_OFS, 32'h0);
        chk(rd, 32'h8000_0000);
    endtask

    // Echo edges test that both paths never double count
    task automatic t_move;
        apb(1'b1, CMD_OFS, 32'h0000_0521);
        repeat (6) @(posedge pclk);
        chk({20'h0, hs_on, ls_on}, 32'h081);
        wait_dr;
        chk({31'h0, dr_line}, 32'h0);
        chk({26'h0, hs_on | ls_on}, 32'h0);
        chk({30'h0, gain_sel[1:0]}, 32'h2);
        apb(1'b0, STAT1_OFS, 32'h0);
        chk(rd, 32'h0010_0007);
        // Done clears at the access edge, so look one edge later
        @(posedge pclk);
        chk({31'h0, dr_line}, 32'h1);
    endtask

    task automatic t_stall;
        stalled <= 1'b1;
        apb(1'b1, CMD_OFS, 32'h0000_0521);
        wait_dr;
        apb(1'b0, STAT1_OFS, 32'h0);
        chk(rd, 32'h0012_0000);
    endtask

    // Motor stays stalled, so counts stay zero; alt picks the other fault inputs
    task automatic t_fault(input logic alt);
        apb(1'b1, CMD_OFS, 32'h0000_0521);
        bat_hi <= ~alt;
        bat_lo <= alt;
        repeat (4) @(posedge pclk);
        bat_hi <= 1'b0;
        bat_lo <= 1'b0;
        chk({20'h0, hs_on, ls_on}, 32'h003);
        chk({29'h0, sense_v}, 32'h1);
        wait_dr;
        apb(1'b0, STAT1_OFS, 32'h0);
        chk(rd, 32'h0014_0000);
        apb(1'b1, CMD_OFS, alt ? 32'h0000_0524 : 32'h0000_0521);
        apb(1'b1, CMD_OFS, 32'h0000_0521);
        apb(1'b0, CMD_OFS, 32'h0);
        chk(rd, 32'h8000_0521);
        chk({20'h0, hs_on, ls_on}, alt ? 32'h102 : 32'h081);
        chk({29'h0, mux_v}, {31'h0, alt});
        oc_bits <= alt ? 6'h00 : 6'h02;
        hot <= alt;
        @(posedge pclk);
        oc_bits <= 6'h00;
        hot <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({20'h0, hs_on, ls_on}, 32'h000);
        apb(1'b0, STAT1_OFS, 32'h0);
        chk(rd, 32'h0018_0000);
    endtask

    task automatic end_sim;
        $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        forever #5 pclk = ~pclk;
    end

    initial begin
        #100_000;
        error_cnt++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_bad;
        t_move;
        t_stall;
        t_fault(1'b0);
        t_fault(1'b1);
        end_sim;
    end
endmodule
